/* File: src/rtp_pkg.sv */
// Notes on behaviour
// - A channel trips at once when its reading exceeds its threshold.
// - Each channel has a delayed alarm with own threshold and enable.
// - A set trip or alarm releases only below 0.99 of its threshold.
// - A global and per-channel enable silence whatever is off.
// - Channels form winding 1, winding 2, ambient and auxiliary groups.
// - Each group trip is evaluated on the hottest reading among its enabled channels.
// - An active vote trips when enough of its selected channels are tripped.
// - A selected channel counts only if it and the global function are on.
// - The final trip is either the OR of channel and group trips or of vote trips.
// - Collective alarm is the OR of all groups; collective trip ORs channel and group trips.
// - The collective timeout is any channel or group timeout.
// - The trip block input masks channel and group trips at the outputs and suppresses all vote trips.
// - Eleven temperature channels are evaluated.
package rtp_pkg;
    localparam int NCH        = 11;
    localparam int NGRP       = 4;
    localparam int NVOTE      = 2;
    localparam int LINK_SLOTS = 12;
    localparam int TW         = 16;
    localparam int DROP_NUM   = 99;
    localparam int DROP_DEN   = 100;

    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_CHAN_EN  = 12'h004;
    localparam logic [11:0] OFS_ALARM_EN = 12'h008;
    localparam logic [11:0] OFS_ALM_DLY  = 12'h00C;
    localparam logic [11:0] OFS_VOTE0    = 12'h010;
    localparam logic [11:0] OFS_VOTE1    = 12'h014;
    localparam logic [11:0] OFS_CH_STAT  = 12'h018;
    localparam logic [11:0] OFS_GRP_STAT = 12'h01C;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h024;
    localparam logic [11:0] OFS_TRIP_THR = 12'h040;
    localparam logic [11:0] OFS_ALM_THR  = 12'h080;
    localparam logic [11:0] OFS_GRP_THR  = 12'h0C0;
    localparam logic [11:0] OFS_GRP_MAX  = 12'h0E0;

    localparam int CTRL_GLOBAL_EN = 0;
    localparam int CTRL_TRIP_SRC  = 1;
    localparam int VOTE_ACTIVE    = 0;
    localparam int VOTE_CNT_LSB   = 4;
    localparam int VOTE_SEL_LSB   = 16;
    localparam int IRQ_TRIP       = 0;
    localparam int IRQ_ALARM      = 1;
    localparam int IRQ_TIMEOUT    = 2;
    localparam int NIRQ           = 3;

    localparam logic [TW-1:0] RST_THR     = 16'hFFFF;
    localparam logic [15:0]   RST_ALM_DLY = 16'h0010;
    localparam int            TIMEOUT_CYC = 40000;

    // Group of each channel: 0 winding 1, 1 winding 2, 2 ambient, 3 aux
    localparam logic [1:0] GRP_OF [NCH] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1,
        2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};

    // Pickup strictly above, dropout below 0.99 of threshold
    function automatic logic rtp_over(input logic [TW-1:0] rd,
                                      input logic [TW-1:0] thr,
                                      input logic          held);
        logic [TW+6:0] lhs;
        logic [TW+6:0] rhs;
        lhs = 23'(rd) * 23'(DROP_DEN);
        rhs = 23'(thr) * 23'(DROP_NUM);
        rtp_over = held ? (lhs >= rhs) : (rd > thr);
    endfunction : rtp_over
endpackage : rtp_pkg

/* File: src/rtp_chan.sv */
`timescale 1ns/1ps
module rtp_chan
    import rtp_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          enable,
    input  wire logic          alarm_en,
    input  wire logic [TW-1:0] reading,
    input  wire logic [TW-1:0] trip_thr,
    input  wire logic [TW-1:0] alarm_thr,
    input  wire logic [15:0]   alarm_dly,
    output logic               trip_ff,
    output logic               alarm_ff
);
    logic        alm_pick_ff;
    logic [15:0] dly_cnt_ff;
    logic        alm_over;

    assign alm_over = rtp_over(reading, alarm_thr, alm_pick_ff);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            trip_ff <= 1'b0;
        end else begin
            trip_ff <= enable &&
                rtp_over(reading, trip_thr, trip_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            alm_pick_ff <= 1'b0;
            dly_cnt_ff  <= 16'h0000;
            alarm_ff    <= 1'b0;
        end else if (!(enable && alarm_en && alm_over)) begin
            alm_pick_ff <= 1'b0;
            dly_cnt_ff  <= 16'h0000;
            alarm_ff    <= 1'b0;
        end else begin
            alm_pick_ff <= 1'b1;
            if (dly_cnt_ff >= alarm_dly) begin
                alarm_ff <= 1'b1;
            end else begin
                dly_cnt_ff <= dly_cnt_ff + 16'h0001;
            end
        end
    end
endmodule : rtp_chan

/* File: src/rtp_top.sv */
`timescale 1ns/1ps
module rtp_top
    import rtp_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC
)(
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rd_valid,
    input  wire logic [3:0]    rd_slot,
    input  wire logic [TW-1:0] rd_temp,
    input  wire logic          trip_block,
    output logic               final_trip,
    output logic               all_groups_alarm,
    output logic               all_groups_timeout,
    output logic               all_groups_trip,
    output logic               irq
);
    logic [1:0]      ctrl_ff;
    logic [NCH-1:0]  chan_en_ff;
    logic [NCH-1:0]  alarm_en_ff;
    logic [15:0]     alm_dly_ff;
    logic [31:0]     vote_cfg_ff [NVOTE];
    logic [TW-1:0]   trip_thr_ff [NCH];
    logic [TW-1:0]   alm_thr_ff  [NCH];
    logic [TW-1:0]   grp_thr_ff  [NGRP];
    logic [TW-1:0]   reading_ff  [NCH];
    logic [31:0]     tmo_cnt_ff  [NCH];
    logic [NCH-1:0]  chan_tmo_ff;
    logic [NGRP-1:0] grp_trip_ff;
    logic [NIRQ-1:0] irq_stat_ff;
    logic [NIRQ-1:0] irq_mask_ff;
    logic [NIRQ-1:0] irq_prev_ff;
    logic [31:0]     prdata_ff;
    logic            pslverr_ff;

    logic [NCH-1:0]  ch_trip;
    logic [NCH-1:0]  ch_alarm;
    logic [TW-1:0]   grp_max [NGRP];
    logic [NGRP-1:0] grp_alarm;
    logic [NGRP-1:0] grp_tmo;
    logic [NGRP-1:0] grp_en;
    logic [NVOTE-1:0] vote_trip;
    logic [NIRQ-1:0] irq_evt;
    logic            glob_en;
    logic            setup;
    logic            wr_acc;
    logic            rd_acc;
    logic            stat_rd;

    assign glob_en = ctrl_ff[CTRL_GLOBAL_EN];

    // Readings from the multiplexed link; slot 11 carries no channel
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                reading_ff[i] <= '0;
            end
        end else if (rd_valid && (32'(rd_slot) < NCH)) begin
            reading_ff[rd_slot] <= rd_temp;
        end
    end

    // A channel not refreshed within TIMEOUT cycles raises its timeout
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                tmo_cnt_ff[i]  <= '0;
                chan_tmo_ff[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!(glob_en && chan_en_ff[i])) begin
                    tmo_cnt_ff[i]  <= '0;
                    chan_tmo_ff[i] <= 1'b0;
                end else if (rd_valid && (32'(rd_slot) == i)) begin
                    tmo_cnt_ff[i]  <= '0;
                    chan_tmo_ff[i] <= 1'b0;
                end else if (tmo_cnt_ff[i] >= 32'(TIMEOUT)) begin
                    chan_tmo_ff[i] <= 1'b1;
                end else begin
                    tmo_cnt_ff[i] <= tmo_cnt_ff[i] + 32'd1;
                end
            end
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        rtp_chan u_chan (
            .sys_clk   (sys_clk),
            .rstn      (rstn),
            .enable    (glob_en && chan_en_ff[c]),
            .alarm_en  (alarm_en_ff[c]),
            .reading   (reading_ff[c]),
            .trip_thr  (trip_thr_ff[c]),
            .alarm_thr (alm_thr_ff[c]),
            .alarm_dly (alm_dly_ff),
            .trip_ff   (ch_trip[c]),
            .alarm_ff  (ch_alarm[c])
        );
    end

    // Hottest enabled reading per group
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            grp_max[g]   = '0;
            grp_alarm[g] = 1'b0;
            grp_tmo[g]   = 1'b0;
            grp_en[g]    = 1'b0;
        end
        for (int i = 0; i < NCH; i++) begin
            if (chan_en_ff[i]) begin
                grp_en[GRP_OF[i]] = 1'b1;
                if (reading_ff[i] > grp_max[GRP_OF[i]]) begin
                    grp_max[GRP_OF[i]] = reading_ff[i];
                end
            end
            grp_alarm[GRP_OF[i]] = grp_alarm[GRP_OF[i]] | ch_alarm[i];
            grp_tmo[GRP_OF[i]]   = grp_tmo[GRP_OF[i]] | chan_tmo_ff[i];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            grp_trip_ff <= '0;
        end else begin
            for (int g = 0; g < NGRP; g++) begin
                grp_trip_ff[g] <= glob_en && grp_en[g] &&
                    rtp_over(grp_max[g], grp_thr_ff[g],
                             grp_trip_ff[g]);
            end
        end
    end

    // Votes use unblocked channel states; the block gates each vote result and the collective trip output
    always_comb begin
        logic [4:0] cnt;
        cnt = 5'd0;
        for (int v = 0; v < NVOTE; v++) begin
            cnt = 5'd0;
            for (int i = 0; i < NCH; i++) begin
                if (vote_cfg_ff[v][VOTE_SEL_LSB + i] && chan_en_ff[i] &&
                    glob_en && ch_trip[i]) begin
                    cnt = cnt + 5'd1;
                end
            end
            // A count field of zero trips as soon as the vote is active
            vote_trip[v] = !trip_block && glob_en &&
                vote_cfg_ff[v][VOTE_ACTIVE] &&
                (cnt >= {1'b0, vote_cfg_ff[v][VOTE_CNT_LSB +: 4]});
        end
    end

    assign all_groups_trip    = !trip_block &&
                                ((|ch_trip) || (|grp_trip_ff));
    assign all_groups_alarm   = |grp_alarm;
    assign all_groups_timeout = (|chan_tmo_ff) || (|grp_tmo);
    assign final_trip = ctrl_ff[CTRL_TRIP_SRC] ? (|vote_trip)
                                               : all_groups_trip;

    // APB: zero wait states, read data captured in the setup cycle
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign stat_rd = rd_acc && (paddr == OFS_IRQ_STAT);
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;

    function automatic logic mapped(input logic [11:0] a);
        logic [11:0] t;
        t = a - OFS_TRIP_THR;
        mapped = (a <= OFS_IRQ_MASK) ||
                 ((a >= OFS_TRIP_THR) && (a < OFS_GRP_THR) &&
                  (t[5:2] < 4'(NCH))) ||
                 ((a >= OFS_GRP_THR) && (a < OFS_GRP_THR + 12'h010)) ||
                 ((a >= OFS_GRP_MAX) && (a < OFS_GRP_MAX + 12'h010));
        mapped = mapped && (a[1:0] == 2'b00);
    endfunction : mapped

    // Word of a table at base plus four bytes per entry
    function automatic logic tbl_hit(input logic [11:0] a,
                                     input logic [11:0] base,
                                     input int          idx);
        tbl_hit = (a == base + 12'(4 * idx));
    endfunction : tbl_hit

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff     <= '0;
            chan_en_ff  <= '0;
            alarm_en_ff <= '0;
            alm_dly_ff  <= RST_ALM_DLY;
            irq_mask_ff <= '0;
            for (int v = 0; v < NVOTE; v++) begin
                vote_cfg_ff[v] <= '0;
            end
            for (int i = 0; i < NCH; i++) begin
                trip_thr_ff[i] <= RST_THR;
                alm_thr_ff[i]  <= RST_THR;
            end
            for (int g = 0; g < NGRP; g++) begin
                grp_thr_ff[g] <= RST_THR;
            end
        end else if (wr_acc) begin
            case (paddr)
                OFS_CTRL:     ctrl_ff     <= pwdata[1:0];
                OFS_CHAN_EN:  chan_en_ff  <= pwdata[NCH-1:0];
                OFS_ALARM_EN: alarm_en_ff <= pwdata[NCH-1:0];
                OFS_ALM_DLY:  alm_dly_ff  <= pwdata[15:0];
                OFS_VOTE0:    vote_cfg_ff[0] <= pwdata;
                OFS_VOTE1:    vote_cfg_ff[1] <= pwdata;
                OFS_IRQ_MASK: irq_mask_ff <= pwdata[NIRQ-1:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (tbl_hit(paddr, OFS_TRIP_THR, i)) begin
                            trip_thr_ff[i] <= pwdata[TW-1:0];
                        end
                        if (tbl_hit(paddr, OFS_ALM_THR, i)) begin
                            alm_thr_ff[i] <= pwdata[TW-1:0];
                        end
                    end
                    for (int g = 0; g < NGRP; g++) begin
                        if (tbl_hit(paddr, OFS_GRP_THR, g)) begin
                            grp_thr_ff[g] <= pwdata[TW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    // Read data latched in setup, so no wait state is ever needed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            pslverr_ff <= !mapped(paddr);
            prdata_ff  <= '0;
            if (!pwrite) begin
                case (paddr)
                    OFS_CTRL:     prdata_ff <= {30'h0, ctrl_ff};
                    OFS_CHAN_EN:  prdata_ff <= {21'h0, chan_en_ff};
                    OFS_ALARM_EN: prdata_ff <= {21'h0, alarm_en_ff};
                    OFS_ALM_DLY:  prdata_ff <= {16'h0, alm_dly_ff};
                    OFS_VOTE0:    prdata_ff <= vote_cfg_ff[0];
                    OFS_VOTE1:    prdata_ff <= vote_cfg_ff[1];
                    OFS_CH_STAT:  prdata_ff <= {5'h0, ch_alarm, 5'h0, ch_trip};
                    OFS_GRP_STAT: prdata_ff <= {13'h0, final_trip,
                        all_groups_timeout, all_groups_alarm, 2'h0, vote_trip,
                        grp_tmo, grp_alarm, grp_trip_ff};
                    OFS_IRQ_STAT: prdata_ff <= {29'h0, irq_stat_ff};
                    OFS_IRQ_MASK: prdata_ff <= {29'h0, irq_mask_ff};
                    default: begin
                        for (int i = 0; i < NCH; i++) begin
                            if (tbl_hit(paddr, OFS_TRIP_THR, i)) begin
                                prdata_ff <= {16'h0, trip_thr_ff[i]};
                            end
                            if (tbl_hit(paddr, OFS_ALM_THR, i)) begin
                                prdata_ff <= {16'h0, alm_thr_ff[i]};
                            end
                        end
                        for (int g = 0; g < NGRP; g++) begin
                            if (tbl_hit(paddr, OFS_GRP_THR, g)) begin
                                prdata_ff <= {16'h0, grp_thr_ff[g]};
                            end
                            if (tbl_hit(paddr, OFS_GRP_MAX, g)) begin
                                prdata_ff <= {16'h0, grp_max[g]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Rising edges of final trip, collective alarm and collective timeout; a new edge beats the clear
    assign irq_evt = {all_groups_timeout, all_groups_alarm, final_trip} &
                     ~irq_prev_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_prev_ff <= '0;
            irq_stat_ff <= '0;
        end else begin
            irq_prev_ff <= {all_groups_timeout, all_groups_alarm, final_trip};
            irq_stat_ff <= (stat_rd ? '0 : irq_stat_ff) | irq_evt;
        end
    end

    // Level output, dropped by the status read or by clearing the mask bit
    assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule : rtp_top

/* File: test/rtp_monitor.sv */
`timescale 1ns/1ps
module rtp_monitor
    import rtp_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC
)(
    input wire logic          sys_clk,
    input wire logic          rstn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          rd_valid,
    input wire logic [3:0]    rd_slot,
    input wire logic [TW-1:0] rd_temp,
    input wire logic          trip_block,
    input wire logic          final_trip,
    input wire logic          all_groups_alarm,
    input wire logic          all_groups_timeout,
    input wire logic          all_groups_trip,
    input wire logic          irq
);
    logic [1:0] ctrl_ff;
    logic [2:0] mask_ff;
    logic       wr_acc;
    assign wr_acc = psel && penable && pwrite && pready;
    // Shadows, since the control bits never reach the ports
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= 2'h0;
        end else if (wr_acc && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[1:0];
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_ff <= 3'h0;
        end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
            mask_ff <= pwdata[2:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_trip_rise;
        $rose(final_trip) && mask_ff[IRQ_TRIP];
    endsequence
    sequence s_src_chan;
        (!ctrl_ff[CTRL_TRIP_SRC])[*2] ##0 final_trip;
    endsequence
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_slverr; pslverr |-> psel && penable; endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr outside access");
    property p_blk_fin; trip_block |-> !final_trip; endproperty
    a_blk_fin: assert property (p_blk_fin)
        else $error("final trip while blocked");
    property p_blk_any; trip_block |-> !all_groups_trip; endproperty
    a_blk_any: assert property (p_blk_any)
        else $error("group trip while blocked");
    property p_glob;
        (!ctrl_ff[CTRL_GLOBAL_EN])[*3] |-> !final_trip && !all_groups_alarm;
    endproperty
    a_glob: assert property (p_glob) else $error("output while off");
    property p_src; s_src_chan |-> all_groups_trip; endproperty
    a_src: assert property (p_src) else $error("final without trip");
    property p_vote; ctrl_ff[CTRL_TRIP_SRC] && final_trip |-> ctrl_ff[0];
    endproperty
    a_vote: assert property (p_vote) else $error("vote while off");
    property p_irq_rise; s_trip_rise |=> irq; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq missed");
    property p_irq_off; mask_ff == 3'h0 |-> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
endmodule : rtp_monitor

bind rtp_top rtp_monitor #(.TIMEOUT(TIMEOUT)) rtp_monitor_i (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid),
    .rd_slot(rd_slot), .rd_temp(rd_temp), .trip_block(trip_block),
    .final_trip(final_trip), .all_groups_alarm(all_groups_alarm),
    .all_groups_timeout(all_groups_timeout),
    .all_groups_trip(all_groups_trip), .irq(irq));

/* File: test/rtp_link_model.sv */
`timescale 1ns/1ps
module rtp_link_model
    import rtp_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          pause,
    input  wire logic [3:0]    gap,
    output logic               rd_valid,
    output logic [3:0]         rd_slot,
    output logic [TW-1:0]      rd_temp
);
    logic [TW-1:0] temp [LINK_SLOTS];
    logic [3:0]    wait_ff;
    logic [3:0]    slot_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_slot  <= 4'h0;
            rd_temp  <= 16'h0000;
            wait_ff  <= 4'h0;
            slot_ff  <= 4'h0;
        end else if (pause || wait_ff != 4'h0) begin
            // Idle words carry junk so stale data is never trusted
            rd_valid <= 1'b0;
            rd_slot  <= rd_slot + 4'h1;
            rd_temp  <= ~rd_temp;
            wait_ff  <= (wait_ff != 4'h0) ? wait_ff - 4'h1 : 4'h0;
        end else begin
            rd_valid <= 1'b1;
            rd_slot  <= slot_ff;
            rd_temp  <= temp[slot_ff];
            slot_ff  <= (slot_ff == 4'hB) ? 4'h0 : slot_ff + 4'h1;
            wait_ff  <= gap;
        end
    end
endmodule : rtp_link_model

/* File: test/rtd_temperature_protection_tb_top.sv */
`timescale 1ns/1ps
module rtd_temperature_protection_tb_top import rtp_pkg::*;;
    logic          sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, q;
    logic          rd_valid, trip_block, final_trip, alarm, tmo, trip, irq;
    logic [3:0]    rd_slot, gap;
    logic [TW-1:0] rd_temp;
    logic          pause, slv_err;
    logic [3:0]    lastc [NGRP] = '{4'h2, 4'h5, 4'h7, 4'hA};
    int            miscompares, checks, cyc_cnt;
    rtp_top #(.TIMEOUT(60)) rtp_top_i (.sys_clk(sys_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rd_valid(rd_valid), .rd_slot(rd_slot),
        .rd_temp(rd_temp), .trip_block(trip_block),
        .final_trip(final_trip), .all_groups_alarm(alarm),
        .all_groups_timeout(tmo), .all_groups_trip(trip), .irq(irq));
    rtp_link_model rtp_link_model_i (.sys_clk(sys_clk), .rstn(rstn),
        .pause(pause), .gap(gap), .rd_valid(rd_valid),
        .rd_slot(rd_slot), .rd_temp(rd_temp));
    always #12.5 sys_clk = ~sys_clk;
    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q       = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Sample on the falling edge, after the rising edge updates settle
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc
    task automatic tmp(input int k, input logic [TW-1:0] v);
        rtp_link_model_i.temp[k] = v;
    endtask : tmp
    task automatic s_regs;
        apb(1'b0, OFS_TRIP_THR, 32'h0);
        chk(q, {16'h0000, RST_THR});
        apb(1'b0, OFS_ALM_DLY, 32'h0);
        chk(q, {16'h0000, RST_ALM_DLY});
        apb(1'b1, OFS_CH_STAT, 32'hFFFFFFFF);
        apb(1'b0, OFS_CH_STAT, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({q[31:1], slv_err}, 32'h1);
    endtask : s_regs
    task automatic s_trip;
        for (int i = 0; i < NCH; i++) begin
            tmp(i, 16'h03E8);
            cyc(30);
            chk(trip, 1'b0);
            tmp(i, 16'h03E9);
            cyc(30);
            chk({trip, final_trip}, 2'h3);
            apb(1'b0, OFS_IRQ_STAT, 32'h0);
            chk(q[IRQ_TRIP], 1'b1);
            cyc(1);
            chk(irq, 1'b0);
            tmp(i, 16'h03DE);
            cyc(30);
            chk(final_trip, 1'b1);
            tmp(i, 16'h03DD);
            cyc(30);
            chk(final_trip, 1'b0);
        end
    endtask : s_trip
    task automatic s_block_global;
        tmp(0, 16'h03E9);
        cyc(30);
        @(posedge sys_clk) trip_block <= 1'b1;
        cyc(1);
        chk({trip, final_trip}, 2'h0);
        @(posedge sys_clk) trip_block <= 1'b0;
        cyc(1);
        chk(final_trip, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        cyc(3);
        chk({trip, final_trip}, 2'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_CHAN_EN, 32'h7FE);
        cyc(3);
        chk(trip, 1'b0);
        apb(1'b1, OFS_CHAN_EN, 32'h7FF);
        tmp(0, 16'h0064);
    endtask : s_block_global
    task automatic s_vote;
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b1, OFS_VOTE0, 32'h01110021);
        tmp(0, 16'h03E9);
        cyc(30);
        chk({trip, final_trip}, 2'h2);
        tmp(4, 16'h03E9);
        cyc(30);
        chk(final_trip, 1'b1);
        apb(1'b1, OFS_CHAN_EN, 32'h7EF);
        cyc(3);
        chk(final_trip, 1'b0);
        apb(1'b1, OFS_CHAN_EN, 32'h7FF);
        apb(1'b1, OFS_VOTE0, 32'h01110020);
        apb(1'b1, OFS_VOTE1, 32'h01110021);
        cyc(30);
        chk(final_trip, 1'b1);
        @(posedge sys_clk) trip_block <= 1'b1;
        cyc(1);
        chk(final_trip, 1'b0);
        @(posedge sys_clk) trip_block <= 1'b0;
        cyc(1);
        chk(final_trip, 1'b1);
        apb(1'b1, OFS_VOTE1, 32'h01110030);
        cyc(3);
        chk(final_trip, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h1);
    endtask : s_vote
    task automatic s_group;
        gap <= 4'h3;
        for (int i = 0; i < NCH; i++) tmp(i, 16'h0100 + 16'(i));
        cyc(120);
        for (int g = 0; g < NGRP; g++) begin
            apb(1'b0, OFS_GRP_MAX + 12'(4 * g), 32'h0);
            chk(q, 32'h100 + 32'(lastc[g]));
        end
        apb(1'b1, OFS_GRP_THR + 12'h8, 32'h105);
        cyc(3);
        chk({trip, final_trip}, 2'h3);
        apb(1'b1, OFS_GRP_THR + 12'h8, 32'hFFFF);
        gap <= 4'h0;
        cyc(3);
        chk(trip, 1'b0);
    endtask : s_group
    task automatic s_alarm;
        apb(1'b1, OFS_ALM_THR + 12'hC, 32'h200);
        apb(1'b1, OFS_ALM_DLY, 32'h1E);
        apb(1'b1, OFS_ALARM_EN, 32'h8);
        tmp(3, 16'h0300);
        cyc(14);
        chk(alarm, 1'b0);
        cyc(50);
        chk(alarm, 1'b1);
        tmp(3, 16'h01FB);
        cyc(30);
        chk(alarm, 1'b1);
        tmp(3, 16'h01FA);
        cyc(30);
        chk(alarm, 1'b0);
        tmp(3, 16'h0300);
        apb(1'b1, OFS_ALARM_EN, 32'h0);
        cyc(60);
        chk(alarm, 1'b0);
    endtask : s_alarm
    task automatic s_tmo;
        pause <= 1'b1;
        cyc(80);
        chk(tmo, 1'b1);
        apb(1'b1, OFS_CHAN_EN, 32'h0);
        cyc(3);
        chk(tmo, 1'b0);
        apb(1'b1, OFS_CHAN_EN, 32'h7FF);
        pause <= 1'b0;
        cyc(30);
        chk(tmo, 1'b0);
    endtask : s_tmo
    initial begin
        {sys_clk, rstn, psel, penable, pwrite, trip_block, pause} = 7'h0;
        {paddr, pwdata, gap} = 48'h0;
        for (int i = 0; i < LINK_SLOTS; i++) tmp(i, 16'h0064);
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        s_regs();
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_CHAN_EN, 32'h7FF);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < NCH; i++) begin
            apb(1'b1, OFS_TRIP_THR + 12'(4 * i), 32'h3E8);
        end
        s_trip();
        s_block_global();
        s_vote();
        s_group();
        s_alarm();
        s_tmo();
        complete_run();
    end
endmodule : rtd_temperature_protection_tb_top
